// ---- core/pdr_cap_gate.sv ----
// Decides per channel whether a capacitance measurement follows detection.
// Assumes mode and detection results come from the detection engine.
`timescale 1ns/1ns
`include "pdr_map.svh"
module pdr_cap_gate #(
  parameter int NCH = `PDR_CHANNELS
) (
  input  wire logic           core_clk,
  input  wire logic           sys_rst,
  input  wire logic [NCH-1:0] cap_arm,
  input  wire logic [NCH-1:0] manual_mode,
  input  wire logic [NCH-1:0] res_done,
  input  wire logic [NCH-1:0] res_valid,
  output logic [NCH-1:0]      cap_go
);
  import pdr_pkg::*;
  pdr_cap_st_type st_q, st_d;

  // Request only in manual mode and only after an invalid signature
  always_comb begin
    st_d = st_q;
    st_d.go = cap_arm & manual_mode & res_done & ~res_valid;
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign cap_go = st_q.go;

  // Never requested outside manual mode
  property p_manual_only;
    @(posedge core_clk) disable iff (sys_rst)
      cap_go[0] |-> $past(manual_mode[0]) && $past(cap_arm[0]);
  endproperty
  a_manual_only: assert property (p_manual_only) else $error("Cap outside manual");

  // Valid signature skips the measurement
  property p_skip_valid;
    @(posedge core_clk) disable iff (sys_rst)
      res_valid[1] |=> !cap_go[1];
  endproperty
  a_skip_valid: assert property (p_skip_valid) else $error("Cap after valid signature");
endmodule

// ---- core/pdr_fault_trk.sv ----
// Per-channel two-bit turn-on fault codes.
// Assumes one-cycle event strobes synchronous to core_clk.
`timescale 1ns/1ns
`include "pdr_map.svh"
module pdr_fault_trk #(
  parameter int NCH = `PDR_CHANNELS
) (
  input  wire logic                             core_clk,
  input  wire logic                             sys_rst,
  input  wire pdr_pkg::pdr_fault_ev_type [NCH-1:0] ev,
  input  wire logic [NCH-1:0]                   pec_flag,
  input  wire logic [NCH-1:0]                   alloc_deny,
  input  wire logic                             clr_all,
  output logic [2*NCH-1:0]                      code
);
  import pdr_pkg::*;
  pdr_fault_st_type st_q, st_d;

  // Next-state: a new fault beats a clear-on-read in the same cycle
  always_comb begin
    st_d = st_q;
    if (clr_all) begin
      st_d.code = '0;
    end
    for (int i = 0; i < NCH; i++) begin
      if (ev[i].off_stb) begin
        st_d.code[2*i +: 2] = `PDR_FC_NONE;
      end else if (ev[i].fail_stb && !pec_flag[i]) begin
        // Allocation refusal overrides the reported cause
        st_d.code[2*i +: 2] = alloc_deny[i] ? `PDR_FC_NO_POWER : ev[i].cause;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign code = st_q.code;

  // Off clears the channel code on the next edge
  property p_off_clears;
    @(posedge core_clk) disable iff (sys_rst)
      ev[0].off_stb |=> code[1:0] == 2'h0;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("Off did not clear fault");

  // Denied allocation reports insufficient power
  property p_deny;
    @(posedge core_clk) disable iff (sys_rst)
      ev[0].fail_stb && !ev[0].off_stb && !pec_flag[0] && alloc_deny[0]
      |=> code[1:0] == 2'h3;
  endproperty
  a_deny: assert property (p_deny) else $error("Deny not coded as no power");

  // Fault with change flag set leaves code alone
  property p_pec_hold;
    @(posedge core_clk) disable iff (sys_rst)
      ev[0].fail_stb && pec_flag[0] && !ev[0].off_stb && !clr_all
      |=> code[1:0] == $past(code[1:0]);
  endproperty
  a_pec_hold: assert property (p_pec_hold) else $error("Fault recorded with flag set");

  // Plain fault stores its cause
  property p_cause;
    @(posedge core_clk) disable iff (sys_rst)
      ev[1].fail_stb && !ev[1].off_stb && !pec_flag[1] && !alloc_deny[1]
      |=> code[3:2] == $past(ev[1].cause);
  endproperty
  a_cause: assert property (p_cause) else $error("Fault cause not stored");
endmodule

// ---- core/pdr_map.svh ----
// Register offsets, field layouts and reset values for the port diag/fault/remap bank.
// Assumes inclusion by bare name from the package and design modules.
`ifndef PDR_MAP_SVH
`define PDR_MAP_SVH
`define PDR_CMD_CAP_EN      8'h22
`define PDR_CMD_FAULT_RO    8'h24
`define PDR_CMD_FAULT_RC    8'h25
`define PDR_CMD_CHAN_MAP    8'h26
`define PDR_RST_CAP_EN      8'h00
`define PDR_RST_FAULT       8'h00
`define PDR_RST_CHAN_MAP    8'hE4
`define PDR_FC_NONE         2'h0
`define PDR_FC_BAD_DETECT   2'h1
`define PDR_FC_CLASS_ERR    2'h2
`define PDR_FC_NO_POWER     2'h3
`define PDR_CHANNELS        4
`endif

// ---- core/pdr_pkg.sv ----
// Types shared by the port diag/fault/remap bank.
// Assumes pdr_map.svh supplies the numeric constants.
`include "pdr_map.svh"
package pdr_pkg;
  // One register access from the command decoder
  typedef struct packed {
    logic       wr_stb;   // Write strobe, one cycle
    logic       rd_stb;   // Read strobe, one cycle
    logic [7:0] cmd;      // Command byte
    logic [7:0] wdata;    // Write data byte
  } pdr_req_type;
  // Per-channel turn-on event from the power sequencer
  typedef struct packed {
    logic       fail_stb;   // Failed turn-on attempt, one cycle
    logic [1:0] cause;      // Reported failure cause
    logic       off_stb;    // Channel turned off, one cycle
  } pdr_fault_ev_type;
  // Fault tracker state
  typedef struct packed {
    logic [7:0] code;   // Two bits per channel
  } pdr_fault_st_type;
  // Capacitance gate state
  typedef struct packed {
    logic [3:0] go;     // Per-channel capacitance measurement request
  } pdr_cap_st_type;
  // Top state
  typedef struct packed {
    logic [7:0] cap_en;
    logic [7:0] chan_map;
    logic [7:0] rdata;
    logic       rvalid;
    logic       clr;
  } pdr_top_st_type;
endpackage

// ---- core/pdr_regs.sv ----
// Command-byte register bank: capacitance enable, turn-on fault cause, channel map.
// Assumes a command decoder delivers one-cycle read and write strobes.
// How it works
// - Write-only 22h arms capacitance per channel, even bits
// - Capacitance measured only in manual/diagnostic mode
// - Valid resistance signature skips capacitance measurement
// - Completion flags done, one cycle later
// - 24h reads faults plainly, 25h clears after read
// - Two-bit cause per channel after failed turn-on
// - Turning channel off clears its fault code
// - Start fault without change flag records cause
// - Denied power allocation reports insufficient power
// - 26h read/write map, four two-bit physical selects
`timescale 1ns/1ns
`include "pdr_map.svh"
module pdr_regs #(
  parameter int NCH = `PDR_CHANNELS
) (
  input  wire logic                             core_clk,
  input  wire logic                             sys_rst,
  input  wire pdr_pkg::pdr_req_type             req,
  input  wire pdr_pkg::pdr_fault_ev_type [NCH-1:0] fault_ev,
  input  wire logic [NCH-1:0]                   power_enable_change_flag,
  input  wire logic [NCH-1:0]                   alloc_deny,
  input  wire logic [NCH-1:0]                   manual_mode,
  input  wire logic [NCH-1:0]                   res_done,
  input  wire logic [NCH-1:0]                   res_valid,
  input  wire logic [NCH-1:0]                   cap_meas_done,
  output logic [7:0]                            rd_data,
  output logic                                  rd_valid,
  output logic [NCH-1:0]                        cap_measure_go,
  output logic [NCH-1:0]                        cap_done_pulse,
  output logic [7:0]                            port_channel_map
);
  import pdr_pkg::*;
  pdr_top_st_type st_q, st_d;
  logic [7:0]     fault_code;      // Live fault codes
  logic [NCH-1:0] cap_arm;         // Enable bits gathered from even positions
  logic [NCH-1:0] cap_go_w;        // Gate decision
  logic [NCH-1:0] done_q;          // Registered completion pulses

  // Gather capacitance enables from the even bit positions
  for (genvar i = 0; i < NCH; i++) begin : g_arm
    assign cap_arm[i] = st_q.cap_en[2*i];
  end

  // Fault tracker, cleared by a read of the clear-on-read command.
  // The clear acts on the capture edge itself: a delayed clear would wipe a
  // fault that landed on that edge before the host ever saw it.
  pdr_fault_trk #(.NCH(NCH)) u_fault (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .ev         (fault_ev),
    .pec_flag   (power_enable_change_flag),
    .alloc_deny (alloc_deny),
    .clr_all    (st_d.clr),
    .code       (fault_code)
  );

  // Capacitance gate; the host is expected to have followed the arm sequence
  pdr_cap_gate #(.NCH(NCH)) u_cap (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .cap_arm     (cap_arm),
    .manual_mode (manual_mode),
    .res_done    (res_done),
    .res_valid   (res_valid),
    .cap_go      (cap_go_w)
  );

  // Register next-state and read mux
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    st_d.clr    = 1'b0;
    if (req.wr_stb) begin
      case (req.cmd)
        // Odd bits are reserved and kept at zero
        `PDR_CMD_CAP_EN:   st_d.cap_en = req.wdata & 8'h55;
        // Writes land unchecked; group must be off beforehand
        `PDR_CMD_CHAN_MAP: st_d.chan_map = req.wdata;
        default:           st_d = st_d;                      // Read-only or foreign commands
      endcase
    end
    if (req.rd_stb) begin
      st_d.rvalid = 1'b1;
      case (req.cmd)
        `PDR_CMD_FAULT_RO: st_d.rdata = fault_code;
        `PDR_CMD_FAULT_RC: begin
          st_d.rdata = fault_code;
          st_d.clr   = 1'b1;                            // Same-edge clear; new faults win
        end
        `PDR_CMD_CHAN_MAP: st_d.rdata = st_q.chan_map;
        // Write-only and unknown commands read as zero
        default:           st_d.rdata = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.cap_en   <= `PDR_RST_CAP_EN;
      st_q.chan_map <= `PDR_RST_CHAN_MAP;
      st_q.rdata    <= 8'h00;
      st_q.rvalid   <= 1'b0;
      st_q.clr      <= 1'b0;
      done_q        <= '0;
    end else begin
      st_q   <= st_d;
      done_q <= cap_meas_done;
    end
  end

  assign rd_data          = st_q.rdata;
  assign rd_valid         = st_q.rvalid;
  assign cap_measure_go   = cap_go_w;
  assign cap_done_pulse   = done_q;
  assign port_channel_map = st_q.chan_map;

  // Write to 22h lands masked on the next edge
  property p_cap_write;
    @(posedge core_clk) disable iff (sys_rst)
      req.wr_stb && req.cmd == 8'h22 |=> st_q.cap_en == ($past(req.wdata) & 8'h55);
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("Cap enable write lost");

  // Plain fault read returns current codes
  property p_fault_ro;
    @(posedge core_clk) disable iff (sys_rst)
      req.rd_stb && req.cmd == 8'h24 |=> rd_valid && rd_data == $past(fault_code);
  endproperty
  a_fault_ro: assert property (p_fault_ro) else $error("Fault read wrong");

  // Clearing read empties codes unless a new fault lands
  property p_fault_rc;
    @(posedge core_clk) disable iff (sys_rst)
      req.rd_stb && req.cmd == 8'h25 && fault_ev == '0 |=> st_q.clr && fault_code == 8'h00;
  endproperty
  a_fault_rc: assert property (p_fault_rc) else $error("Clear on read failed");

  // Map write reads back
  property p_map_rw;
    @(posedge core_clk) disable iff (sys_rst)
      req.wr_stb && req.cmd == 8'h26 |=> port_channel_map == $past(req.wdata);
  endproperty
  a_map_rw: assert property (p_map_rw) else $error("Map write lost");

  // Completion pulse follows measurement done by one cycle
  property p_done;
    @(posedge core_clk) disable iff (sys_rst)
      cap_meas_done[0] |=> cap_done_pulse[0];
  endproperty
  a_done: assert property (p_done) else $error("Done pulse missing");
endmodule

// ---- verif/pdr_host_model.sv ----
// Host model: issues command-byte reads and writes to the register bank.
// Assumes requests launch on falling edges of core_clk.
`timescale 1ns/1ns
module pdr_host_model (
  input  wire logic            core_clk,
  output pdr_pkg::pdr_req_type req,
  input  wire logic [7:0]      rd_data,
  input  wire logic            rd_valid
);
  import pdr_pkg::*;
  // Bus idle until the first request
  initial req = '0;
  // One write; the map is rewritten without checking that the group is off
  // Cap enables are set whatever the channel's diagnostic mode is at the time
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge core_clk);
    req = '{wr_stb: 1'b1, rd_stb: 1'b0, cmd: cmd, wdata: data};
    @(negedge core_clk);
    req.wr_stb = 1'b0;
    req.wdata = ~data;  // Released data must not look stale
  endtask
  // One read; waits a bounded time for the registered answer
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output bit ok);
    int n;
    @(negedge core_clk);
    req = '{wr_stb: 1'b0, rd_stb: 1'b1, cmd: cmd, wdata: 8'h00};
    @(negedge core_clk);
    req.rd_stb = 1'b0;
    ok = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask
endmodule

// ---- verif/pdr_regs_tb.sv ----
// Self-checking bench for the diag/fault/remap register bank.
// Assumes four channels; all inputs change on falling edges.
`timescale 1ns/1ns
`include "pdr_map.svh"
module pdr_regs_tb;
  import pdr_pkg::*;
  logic                   core_clk = 1'b0;
  logic                   sys_rst  = 1'b1;
  pdr_req_type            req;
  pdr_fault_ev_type [3:0] fault_ev = '0;
  logic [3:0]             pec = '0, deny = '0, manual = '0, rdone = '0, rvalid = '0, cdone = '0;
  logic [3:0]             go, cdp, arm;
  logic [7:0]             rd_data, pmap, v, exp_code, got;
  logic                   rd_valid, fl, dn, off;
  logic [1:0]             cs;
  int                     bad_count, num_checks, ch;
  bit                     ok;
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  pdr_regs #(.NCH(4)) pdr_regs_i (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
    .fault_ev(fault_ev), .power_enable_change_flag(pec), .alloc_deny(deny),
    .manual_mode(manual), .res_done(rdone), .res_valid(rvalid), .cap_meas_done(cdone),
    .rd_data(rd_data), .rd_valid(rd_valid), .cap_measure_go(go), .cap_done_pulse(cdp),
    .port_channel_map(pmap));
  pdr_host_model pdr_host_model_i (.core_clk(core_clk), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  // Single exit point for the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Byte comparison, four-state exact
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Read and compare; a lost answer ends the run
  task automatic rdc(input logic [7:0] cmd, input logic [7:0] exp, input string name);
    pdr_host_model_i.rd(cmd, got, ok);
    if (!ok) begin
      bad_count++;
      print_verdict();
    end else begin
      chk(name, exp, got);
    end
  endtask
  // Expected fault field after one event; off wins, a flagged start fault is ignored
  function automatic logic [7:0] fnext(logic [7:0] c, int n, logic [1:0] cause,
                                       logic o, logic f, logic d);
    if (o) c[2*n+:2] = `PDR_FC_NONE;
    else if (!f) c[2*n+:2] = d ? `PDR_FC_NO_POWER : cause;
    return c;
  endfunction
  // Main sequence
  initial begin
    void'($urandom(70));
    repeat (10) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 1'b0;
    chk("map_out", `PDR_RST_CHAN_MAP, pmap);
    rdc(`PDR_CMD_CHAN_MAP, `PDR_RST_CHAN_MAP, "map_rd");
    rdc(`PDR_CMD_FAULT_RO, `PDR_RST_FAULT, "fault_rd");
    rdc(`PDR_CMD_CAP_EN, 8'h00, "cap_en_rd");
    // Map writes back to back with refused writes to the fault cause
    repeat (4) begin
      v = 8'($urandom);
      pdr_host_model_i.wr(`PDR_CMD_CHAN_MAP, v);
      pdr_host_model_i.wr(`PDR_CMD_FAULT_RO, 8'hFF);
      pdr_host_model_i.wr(`PDR_CMD_FAULT_RC, 8'hFF);
      chk("map_out", v, pmap);
      rdc(`PDR_CMD_CHAN_MAP, v, "map_rd");
      rdc(`PDR_CMD_FAULT_RO, 8'h00, "fault_rd");
    end
    // Capacitance arming against mode and resistance result
    repeat (6) begin
      v = 8'($urandom);
      pdr_host_model_i.wr(`PDR_CMD_CAP_EN, v);
      for (int k = 0; k < 4; k++) arm[k] = v[2*k];
      repeat (3) begin
        @(negedge core_clk);
        manual = 4'($urandom);
        rvalid = 4'($urandom);
        rdone = 4'($urandom);
        cdone = 4'($urandom);
        @(negedge core_clk);
        chk("cap_go", {4'h0, arm & manual & rdone & ~rvalid}, {4'h0, go});
        chk("cap_done", {4'h0, cdone}, {4'h0, cdp});
        rdone = '0;
        cdone = '0;
      end
    end
    // Fault events, every cause code, flags, denials and turn-offs
    exp_code = 8'h00;
    for (int i = 0; i < 24; i++) begin
      ch = $urandom_range(3);
      cs = 2'(i);
      off = ($urandom_range(3) == 0);
      fl = 1'($urandom);
      dn = fl ? 1'b0 : 1'($urandom);
      @(negedge core_clk);
      fault_ev[ch] = '{fail_stb: !off, cause: cs, off_stb: off};
      pec[ch] = fl;
      deny[ch] = dn;
      @(negedge core_clk);
      fault_ev = '0;
      deny = '0;
      exp_code = fnext(exp_code, ch, cs, off, fl, dn);
      rdc(`PDR_CMD_FAULT_RO, exp_code, "fault_ro");
    end
    rdc(`PDR_CMD_FAULT_RC, exp_code, "fault_rc");
    rdc(`PDR_CMD_FAULT_RO, 8'h00, "fault_cleared");
    // Clearing read on the same edge as a new fault: the new fault survives
    pec = '0;
    fork
      rdc(`PDR_CMD_FAULT_RC, 8'h00, "race_rc");
      begin
        @(negedge core_clk);
        fault_ev[0] = '{fail_stb: 1'b1, cause: `PDR_FC_BAD_DETECT, off_stb: 1'b0};
        @(negedge core_clk);
        fault_ev = '0;
      end
    join
    rdc(`PDR_CMD_FAULT_RO, {6'h00, `PDR_FC_BAD_DETECT}, "race_kept");
    // Second reset in mid-run restores the map
    pdr_host_model_i.wr(`PDR_CMD_CHAN_MAP, 8'h1B);
    @(negedge core_clk) sys_rst = 1'b1;
    @(negedge core_clk) sys_rst = 1'b0;
    chk("map_rst2", `PDR_RST_CHAN_MAP, pmap);
    print_verdict();
  end
endmodule
